// >>> core/asr_pkg.sv
// Package: register map, field positions and sampling constants of the receiver
package asr_pkg;
  // Register offsets (word index)
  localparam logic [1:0] STATUS_OFS = 2'h0;
  localparam logic [1:0] DATA_OFS   = 2'h1;
  localparam logic [1:0] CTRL_OFS   = 2'h2;
  localparam logic [1:0] BAUD_OFS   = 2'h3;
  // Status register bit positions
  localparam int PE_BIT  = 2;
  localparam int DOR_BIT = 3;
  localparam int FE_BIT  = 4;
  localparam int RXC_BIT = 7;
  // Control register bit positions
  localparam int RXEN_BIT  = 0;
  localparam int U2X_BIT   = 1;
  localparam int PTYPE_BIT = 2;
  localparam int PEN_BIT   = 3;
  localparam int SBS_BIT   = 4;
  localparam int CSZ_POS   = 5;
  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  // Sampling: last sample index per bit, first vote sample; data bit base and buffer depth
  localparam logic [3:0] SPB_NORM   = 4'hF;
  localparam logic [3:0] SPB_DOUBLE = 4'h7;
  localparam logic [3:0] VOTE_NORM  = 4'h8;
  localparam logic [3:0] VOTE_DBL   = 4'h4;
  localparam logic [3:0] DATA_BITS_BASE = 4'h5;
  localparam logic [1:0] FIFO_FULL  = 2'h2;
endpackage

// >>> core/asr_rx.sv
// Asynchronous receiver: sampling, voting, frame checks and two-entry buffer
`timescale 1ns/1ns

// What this block does
// - Each buffered character carries its own frame, overrun and parity flags.
// - Software writes to status error bits change nothing.
// - Error flags raise no interrupt.
// - Frame error is zero for high first stop bit, one for low.
// - Only the first stop bit is checked; stop count setting ignored.
// - Overrun when buffer full, shift register full and new start seen.
// - Overrun cleared when a frame moves into the buffer.
// - Parity error reads zero while parity checking is off.
// - Parity error only if mismatch and checking enabled at reception.
// - Parity error stays valid until the data register is read.
// - Upper parity bit enables checker; lower picks odd or even.
// - Clearing receive enable stops reception and drops partial frame.
// - Disabling empties the buffer and releases the receive pin.
// - Sample at 16x baud normally, 8x in double speed.
// - Double speed when speed-doubling bit is one.
// - Start detection on high-to-low edge; first low sample is one.
// - Vote samples 8,9,10 or 4,5,6; majority high rejects start.
// - Sixteen or eight sample states per bit.
// - Each bit decided by majority of the three centre samples.
// - Voting starts at sample 8 normally, sample 4 double speed.
// - Low stop sets frame error; normal mode accepts next start right after last vote, double speed only after a further high sample.
module asr_rx (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [1:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rdata,
  // Serial line
  input  wire logic        serial_receive_pin,
  output logic             rx_pin_owned
);

  typedef enum logic [1:0] {ASR_IDLE, ASR_START, ASR_BITS} asr_state_t;

  asr_state_t  state_reg;
  logic [7:0]  ctrl_reg;
  logic [15:0] baud_reg;
  logic [15:0] div_reg;
  logic        tick;
  logic [1:0]  sync_reg;
  logic        line_prev_reg;
  logic [3:0]  samp_reg;
  logic [3:0]  bit_idx_reg;
  logic [2:0]  votes_reg;
  logic [8:0]  shift_reg;
  logic        shift_full_reg;
  logic        shift_fe_reg;
  logic        shift_pe_reg;
  logic [7:0]  shift_data_reg;
  logic        ovr_pend_reg;
  logic [10:0] fifo_mem [2];
  logic        rd_ptr_reg;
  logic        wr_ptr_reg;
  logic [1:0]  count_reg;
  logic        rxen;
  logic        dbl;
  logic [3:0]  spb;
  logic [3:0]  vfirst;
  logic [3:0]  nbits;
  logic        line;
  logic        vote;
  logic        last_vote;
  logic        stop_vote;
  logic        push;
  logic        pop;
  logic [10:0] head;

  function automatic logic majority(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  assign rxen   = ctrl_reg[asr_pkg::RXEN_BIT];
  assign dbl    = ctrl_reg[asr_pkg::U2X_BIT];
  assign spb    = dbl ? asr_pkg::SPB_DOUBLE : asr_pkg::SPB_NORM;
  assign vfirst = dbl ? asr_pkg::VOTE_DBL : asr_pkg::VOTE_NORM;
  // Data bits 5..8 plus optional parity; stop bit count never counted
  assign nbits  = asr_pkg::DATA_BITS_BASE
                + {2'h0, ctrl_reg[asr_pkg::CSZ_POS +: 2]}
                + {3'h0, ctrl_reg[asr_pkg::PEN_BIT]};
  assign line   = sync_reg[1];
  assign vote   = majority({line, votes_reg[1:0]});
  assign last_vote = tick && state_reg != ASR_IDLE
                   && samp_reg == vfirst + 4'h2;
  assign stop_vote = last_vote && state_reg == ASR_BITS
                   && bit_idx_reg == nbits;
  assign head   = fifo_mem[rd_ptr_reg];
  assign pop    = rd_en && addr == asr_pkg::DATA_OFS && count_reg != 2'h0;
  assign push   = shift_full_reg && count_reg != asr_pkg::FIFO_FULL;

  // Control and baud registers; writes to status are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= asr_pkg::CTRL_RST;
      baud_reg <= asr_pkg::BAUD_RST;
    end else if (wr_en) begin
      // Status writes fall through: error bits are buffer state
      if (addr == asr_pkg::CTRL_OFS) ctrl_reg <= wdata;
      if (addr == asr_pkg::BAUD_OFS) baud_reg <= {8'h00, wdata};
    end
  end

  // Oversample enable divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 16'h0000;
      tick    <= 1'b0;
    end else if (!rxen || div_reg >= baud_reg) begin
      div_reg <= 16'h0000;
      tick    <= rxen;
    end else begin
      div_reg <= div_reg + 16'h0001;
      tick    <= 1'b0;
    end
  end

  // Pin synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sync_reg <= 2'b11;
    else        sync_reg <= {sync_reg[0], serial_receive_pin};
  end

  // Pin ownership follows the enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rx_pin_owned <= 1'b0;
    else        rx_pin_owned <= rxen;
  end

  // Clock and data recovery
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ASR_IDLE;
      line_prev_reg <= 1'b1;
      samp_reg      <= 4'h0;
      bit_idx_reg   <= 4'h0;
      votes_reg     <= 3'h0;
      shift_reg     <= 9'h000;
    end else if (!rxen) begin
      state_reg     <= ASR_IDLE;
      line_prev_reg <= 1'b1;
      samp_reg      <= 4'h0;
      bit_idx_reg   <= 4'h0;
    end else if (tick) begin
      line_prev_reg <= line;
      unique case (state_reg)
        ASR_IDLE: begin
          if (line_prev_reg && !line) begin
            state_reg <= ASR_START;
            samp_reg  <= 4'h2;
          end
        end
        ASR_START: begin
          samp_reg <= samp_reg + 4'h1;
          if (samp_reg >= vfirst && samp_reg < vfirst + 4'h2)
            votes_reg <= {votes_reg[1:0], line};
          if (samp_reg == vfirst + 4'h2) begin
            if (vote) begin
              state_reg <= ASR_IDLE;
            end else begin
              state_reg   <= ASR_BITS;
              bit_idx_reg <= 4'h0;
            end
          end
          if (samp_reg == spb) samp_reg <= 4'h0;
        end
        ASR_BITS: begin
          samp_reg <= (samp_reg == spb) ? 4'h0 : samp_reg + 4'h1;
          if (samp_reg >= vfirst && samp_reg < vfirst + 4'h2)
            votes_reg <= {votes_reg[1:0], line};
          if (samp_reg == vfirst + 4'h2) begin
            shift_reg   <= {vote, shift_reg[8:1]};
            bit_idx_reg <= bit_idx_reg + 4'h1;
            if (bit_idx_reg == nbits) begin
              // Normal mode may restart right away; double speed waits
              state_reg <= ASR_IDLE;
              line_prev_reg <= dbl ? 1'b0 : line;
            end
          end
        end
        default: state_reg <= ASR_IDLE;
      endcase
    end
  end

  // Shift register hold and overrun detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_full_reg <= 1'b0;
      shift_fe_reg   <= 1'b0;
      shift_pe_reg   <= 1'b0;
      shift_data_reg <= 8'h00;
      ovr_pend_reg   <= 1'b0;
    end else if (!rxen) begin
      shift_full_reg <= 1'b0;
      ovr_pend_reg   <= 1'b0;
    end else begin
      if (push) shift_full_reg <= 1'b0;
      // A waiting character is kept; the newer frame is the one lost
      if (stop_vote && (!shift_full_reg || push)) begin
        shift_full_reg <= 1'b1;
        shift_fe_reg   <= ~vote;
        // Stop bit not shifted yet: data sit just below bit nine
        shift_data_reg <= 8'(shift_reg >> (4'h9 - nbits))
                        & (8'hFF >> (2'h3 - ctrl_reg[asr_pkg::CSZ_POS +: 2]));
        // Parity over data bits and received parity bit; even when type bit low
        shift_pe_reg   <= ctrl_reg[asr_pkg::PEN_BIT]
                        & (^{ctrl_reg[asr_pkg::PTYPE_BIT],
                             shift_reg >> (4'h9 - nbits)});
      end
      // New start while both buffer and shift register are full
      if (tick && state_reg == ASR_IDLE && line_prev_reg && !line
          && shift_full_reg && !push)
        ovr_pend_reg <= 1'b1;
      else if (push)
        ovr_pend_reg <= 1'b0;
    end
  end

  // Two-entry buffer: data, parity, overrun and frame flags per character
  always_ff @(posedge clk) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= {shift_fe_reg, ovr_pend_reg,
                               shift_pe_reg, shift_data_reg};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else if (!rxen) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)  rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // Read data one cycle later; flags come from the buffer head, parity also gated by the enable bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      unique case (addr)
        asr_pkg::STATUS_OFS: begin
          rdata <= 8'h00;
          if (count_reg != 2'h0) begin
            rdata[asr_pkg::RXC_BIT] <= 1'b1;
            rdata[asr_pkg::FE_BIT]  <= head[10];
            rdata[asr_pkg::DOR_BIT] <= head[9];
            rdata[asr_pkg::PE_BIT]  <= head[8]
                                     & ctrl_reg[asr_pkg::PEN_BIT];
          end
        end
        asr_pkg::DATA_OFS: rdata <= count_reg != 2'h0 ? head[7:0] : 8'h00;
        asr_pkg::CTRL_OFS: rdata <= ctrl_reg;
        asr_pkg::BAUD_OFS: rdata <= baud_reg[7:0];
      endcase
    end
  end
  // No interrupt output exists for the error flags

  // Assertions
  property p_flush;
    @(posedge clk) disable iff (!rst_n)
      !rxen |=> count_reg == 2'h0 && !shift_full_reg;
  endproperty
  a_flush: assert property (p_flush) else $error("buffer kept on disable");

  property p_abort;
    @(posedge clk) disable iff (!rst_n)
      !rxen |=> state_reg == ASR_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("frame not dropped");

  property p_pin;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> rx_pin_owned == $past(rxen);
  endproperty
  a_pin: assert property (p_pin) else $error("pin ownership wrong");

  property p_pe_off;
    @(posedge clk) disable iff (!rst_n)
      rd_en && addr == asr_pkg::STATUS_OFS && !ctrl_reg[asr_pkg::PEN_BIT]
      |=> !rdata[asr_pkg::PE_BIT];
  endproperty
  a_pe_off: assert property (p_pe_off) else $error("parity flag set");

  property p_ovr_clr;
    @(posedge clk) disable iff (!rst_n)
      push && rxen |=> !ovr_pend_reg;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun kept");

  property p_count;
    @(posedge clk) disable iff (!rst_n)
      count_reg <= asr_pkg::FIFO_FULL;
  endproperty
  a_count: assert property (p_count) else $error("buffer overfilled");

  property p_status_wr;
    @(posedge clk) disable iff (!rst_n)
      wr_en && addr == asr_pkg::STATUS_OFS |=> $stable(ctrl_reg);
  endproperty
  a_status_wr: assert property (p_status_wr) else $error("status write");

  property p_start_rej;
    @(posedge clk) disable iff (!rst_n)
      rxen && tick && state_reg == ASR_START
      && samp_reg == vfirst + 4'h2 && vote |=> state_reg == ASR_IDLE;
  endproperty
  a_start_rej: assert property (p_start_rej) else $error("noise start");

  // Falling edge seen on a tick while hunting for a start bit
  sequence s_start_edge;
    rxen && tick && state_reg == ASR_IDLE && line_prev_reg && !line;
  endsequence

  // Third vote of a stop bit whose frame has room to be kept
  sequence s_stop_kept;
    rxen && stop_vote && (!shift_full_reg || push);
  endsequence

  property p_start;
    @(posedge clk) disable iff (!rst_n)
      s_start_edge |=> state_reg == ASR_START && samp_reg == 4'h2;
  endproperty
  a_start: assert property (p_start) else $error("start missed");

  property p_ovr_set;
    @(posedge clk) disable iff (!rst_n)
      s_start_edge ##0 (shift_full_reg && !push) |=> ovr_pend_reg;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun missed");

  property p_fe;
    @(posedge clk) disable iff (!rst_n)
      s_stop_kept |=> shift_full_reg && shift_fe_reg == !$past(vote);
  endproperty
  a_fe: assert property (p_fe) else $error("frame error wrong");

  property p_pe_gate;
    @(posedge clk) disable iff (!rst_n)
      s_stop_kept ##0 !ctrl_reg[asr_pkg::PEN_BIT] |=> !shift_pe_reg;
  endproperty
  a_pe_gate: assert property (p_pe_gate) else $error("parity kept");

  property p_restart;
    @(posedge clk) disable iff (!rst_n)
      rxen && stop_vote && dbl |=> state_reg == ASR_IDLE && !line_prev_reg;
  endproperty
  a_restart: assert property (p_restart) else $error("early restart");

  property p_pop;
    @(posedge clk) disable iff (!rst_n)
      rxen && pop && !push |=> count_reg == $past(count_reg) - 2'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("read did not advance");

  property p_wrap;
    @(posedge clk) disable iff (!rst_n)
      rxen && tick && state_reg == ASR_BITS && samp_reg == spb
      |=> samp_reg == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("bit length wrong");

  property p_resync;
    @(posedge clk) disable iff (!rst_n)
      rxen && tick && state_reg == ASR_START
      && samp_reg == vfirst + 4'h2 && !vote |=> state_reg == ASR_BITS;
  endproperty
  a_resync: assert property (p_resync) else $error("start lost");

endmodule // asr_rx

// >>> dv/asr_rx_bench.sv
// Bench for the serial receiver: register tasks, scenarios, verdict
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module asr_rx_bench;
  localparam logic [1:0] ST  = asr_pkg::STATUS_OFS;
  localparam logic [1:0] DT  = asr_pkg::DATA_OFS;
  localparam logic [1:0] CT  = asr_pkg::CTRL_OFS;
  localparam logic [7:0] CTL = 8'h61;
  // Baud value 1: two clocks per sample, 32 clocks per bit
  localparam int         CPB = 32;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] rdata;
  logic       line;
  logic       owned;
  int         miscompares = 0;
  int         samples_checked = 0;

  always #50 clk = ~clk;

  asr_rx u_asr_rx (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .serial_receive_pin(line), .rx_pin_owned(owned));
  asr_tx_model u_asr_tx_model (.clk(clk), .line(line));

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    q = rdata;
  endtask

  task automatic tx(input logic [7:0] d, input logic pen, input logic pb,
                    input logic st);
    u_asr_tx_model.send(d, pen, pb, st, CPB);
  endtask

  // Status first, then data, since a data read moves the buffer
  task automatic chk(input logic [7:0] d, input logic [2:0] f);
    logic [7:0] s;
    logic [7:0] q;
    rd(ST, s);
    `CHK("status", ({3'b100, f, 2'b00}), s & 8'h9C)
    rd(DT, q);
    `CHK("data", d, q)
  endtask

  task automatic t_basic;
    logic [7:0] s;
    rd(ST, s);
    `CHK("idle status", 8'h00, s & 8'h9C)
    `CHK("pin idle", 1'b0, owned)
    wr(asr_pkg::BAUD_OFS, 8'h01);
    wr(CT, CTL);
    repeat (2) @(posedge clk);
    `CHK("pin taken", 1'b1, owned)
    tx(8'hA5, 1'b0, 1'b0, 1'b1);
    tx(8'h3C, 1'b0, 1'b0, 1'b1);
    chk(8'hA5, 3'b000);
    chk(8'h3C, 3'b000);
  endtask

  task automatic t_frame;
    wr(CT, CTL | 8'h10);
    tx(8'h0F, 1'b0, 1'b0, 1'b0);
    repeat (CPB) @(posedge clk);
    tx(8'hF0, 1'b0, 1'b0, 1'b1);
    wr(ST, 8'h00);
    chk(8'h0F, 3'b100);
    chk(8'hF0, 3'b000);
  endtask

  task automatic t_parity;
    logic [7:0] d;
    for (int k = 0; k < 4; k++) begin
      d = 8'h31 + 8'(k);
      wr(CT, CTL | 8'h08 | (k[1] ? 8'h04 : 8'h00));
      tx(d, 1'b1, ^d ^ k[1] ^ k[0], 1'b1);
      chk(d, {2'b00, k[0]});
    end
    wr(CT, CTL | 8'h08);
    tx(8'h07, 1'b1, 1'b0, 1'b1);
    wr(CT, CTL);
    chk(8'h07, 3'b000);
  endtask

  task automatic t_speed_noise;
    logic [7:0] s;
    wr(CT, CTL | 8'h02);
    u_asr_tx_model.send(8'hC3, 1'b0, 1'b0, 1'b1, CPB / 2);
    chk(8'hC3, 3'b000);
    wr(CT, CTL);
    // Low for three samples only: the centre vote sees high
    u_asr_tx_model.put(1'b0, 6);
    u_asr_tx_model.put(1'b1, 2 * CPB);
    rd(ST, s);
    `CHK("after glitch", 1'b0, s[7])
    tx(8'h81, 1'b0, 1'b0, 1'b1);
    chk(8'h81, 3'b000);
  endtask

  task automatic t_overrun;
    logic [7:0] s;
    logic [7:0] q;
    tx(8'h11, 1'b0, 1'b0, 1'b1);
    tx(8'h22, 1'b0, 1'b0, 1'b1);
    tx(8'h33, 1'b0, 1'b0, 1'b1);
    tx(8'h44, 1'b0, 1'b0, 1'b1);
    chk(8'h11, 3'b000);
    chk(8'h22, 3'b000);
    rd(ST, s);
    `CHK("overrun", 1'b1, s[asr_pkg::DOR_BIT])
    for (int n = 0; n < 4 && s[7] === 1'b1; n++) begin
      rd(DT, q);
      rd(ST, s);
    end
    `CHK("drained", 1'b0, s[7])
    tx(8'h55, 1'b0, 1'b0, 1'b1);
    chk(8'h55, 3'b000);
  endtask

  task automatic t_disable;
    logic [7:0] s;
    tx(8'h66, 1'b0, 1'b0, 1'b1);
    fork
      tx(8'h99, 1'b0, 1'b0, 1'b1);
      begin
        repeat (4 * CPB) @(posedge clk);
        wr(CT, 8'h00);
      end
    join
    `CHK("pin released", 1'b0, owned)
    rd(ST, s);
    `CHK("flushed", 8'h00, s & 8'h9C)
    wr(CT, CTL);
    repeat (12 * CPB) @(posedge clk);
    rd(ST, s);
    `CHK("no partial", 8'h00, s & 8'h9C)
    tx(8'h77, 1'b0, 1'b0, 1'b1);
    chk(8'h77, 3'b000);
  endtask

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_basic;
    t_frame;
    t_parity;
    t_speed_noise;
    t_overrun;
    t_disable;
    print_verdict;
  end

  // About 20 frames of 320 clocks each are expected
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
endmodule // asr_rx_bench

// >>> dv/asr_tx_model.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/1ns
module asr_tx_model (
  // Clock
  input  wire logic clk,
  // Serial line, idle high
  output logic      line
);
  initial line = 1'b1;

  // Hold one level for cpb clocks
  task automatic put(input logic v, input int cpb);
    line <= v;
    repeat (cpb) @(posedge clk);
  endtask

  // Start, eight data bits LSB first, optional parity, one stop
  task automatic send(input logic [7:0] d, input logic pen,
                      input logic pbit, input logic stop, input int cpb);
    @(posedge clk);
    put(1'b0, cpb);
    for (int i = 0; i < 8; i++) put(d[i], cpb);
    if (pen) put(pbit, cpb);
    put(stop, cpb);
    // Released line returns to idle high, as with a pull-up
    line <= 1'b1;
  endtask
endmodule // asr_tx_model
